// ==== rtl/fmcr_pkg.sv ====
// Package: register map, field positions, reset values and timing counts
package fmcr_pkg;
    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] FAN_START_TEMP_CTRL1_OFS      = 8'h36;
    localparam logic [7:0] FAN_START_TEMP_ADJ_CYCLE_OFS  = 8'h37;
    localparam logic [7:0] MON_GLOBAL_CFG_OFS  = 8'h40;
    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] FAN_START_TEMP_CTRL1_RST      = 8'h00;
    localparam logic [7:0] FAN_START_TEMP_ADJ_CYCLE_RST  = 8'h00;
    localparam logic [7:0] MON_GLOBAL_CFG_RST  = 8'h00;
    localparam logic [7:0] RSVD_READ_VAL       = 8'h00;
    localparam logic [7:0] CTRL1_RSVD_MASK     = 8'h02;
    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int REMOTE_A_LSB   = 0;
    localparam int LOCAL_LSB      = 3;
    localparam int REMOTE_B_LSB   = 6;
    localparam int CTRL1_RB_MSB   = 0;
    localparam int CFG_RUN        = 0;
    localparam int CFG_LOCK       = 1;
    localparam int CFG_READY      = 2;
    localparam int CFG_FANS_MAX   = 3;
    localparam int CFG_RSVD       = 4;
    localparam int CFG_SPIN_BYP   = 5;
    localparam int CFG_TO_OFF     = 6;
    localparam int CFG_VCC_5V     = 7;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_HZ          = 100_000_000;
    localparam int MON_CYCLE_US    = 125000;
    localparam int MON_CYCLE_CLKS  = (CLK_HZ / 1_000_000) * MON_CYCLE_US;
    localparam int DEC_BASE_CYCLES = 4;
    localparam int READY_DELAY_US  = 100;
    localparam int READY_CLKS      = (CLK_HZ / 1_000_000) * READY_DELAY_US;
endpackage : fmcr_pkg

// ==== rtl/fmcr_adj_timer.sv ====
// Per-channel adjustment delay timer
`timescale 1ns/1ps
module fmcr_adj_timer #(
    parameter int CNT_W = 11
) (
    input  wire logic       mclk_in,
    input  wire logic       rst_in,
    input  wire logic       cycle_tick_in,
    input  wire logic [2:0] code_in,
    input  wire logic       dir_up_in,
    input  wire logic       adjusted_in,
    output logic            due_out
);
    // Elaboration check: the longest increase delay needs 11 bits
    if (CNT_W < 11) begin : g_bad_cnt_w
        $error("CNT_W too small for 1024 cycles");
    end

    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] dec_lim;
    logic [CNT_W-1:0] lim;

    // Decrease delay 4 << code, increase delay twice that
    assign dec_lim = CNT_W'(fmcr_pkg::DEC_BASE_CYCLES) << code_in;
    assign lim     = dir_up_in ? (dec_lim << 1) : dec_lim;

    // Counter restarts after each adjustment, saturates at its limit
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            cnt_r   <= '0;
            due_out <= 1'b0;
        end else begin
            if (adjusted_in) begin
                cnt_r <= '0;
            end else if (cycle_tick_in && cnt_r < lim) begin
                cnt_r <= cnt_r + 1'b1;
            end
            due_out <= !adjusted_in && (cnt_r >= lim);
        end
    end
endmodule : fmcr_adj_timer

// ==== rtl/fmcr_regs.sv ====
// Configuration register bank with lock, ready and adjustment timers
`timescale 1ns/1ps
module fmcr_regs #(
    parameter int MON_CYCLE_CLKS = fmcr_pkg::MON_CYCLE_CLKS,
    parameter int READY_CLKS     = fmcr_pkg::READY_CLKS,
    parameter int CNT_W          = 11
) (
    input  wire logic       mclk_in,
    input  wire logic       rst_in,
    input  wire logic       reg_wr_in,
    input  wire logic       reg_rd_in,
    input  wire logic [7:0] reg_addr_in,
    input  wire logic [7:0] reg_wdata_in,
    input  wire logic [2:0] adj_dir_up_in,
    input  wire logic [2:0] adj_done_in,
    output logic [7:0]      reg_rdata_out,
    output logic [2:0]      remote_a_cycle_code_out,
    output logic [2:0]      local_cycle_code_out,
    output logic [2:0]      remote_b_cycle_code_out,
    output logic            use_programmed_limits_out,
    output logic            limits_locked_out,
    output logic            monitor_ready_out,
    output logic            fans_max_override_out,
    output logic            spinup_pulse_bypass_out,
    output logic            bus_timeout_off_out,
    output logic            vcc_5v_scale_out,
    output logic            monitor_tick_out,
    output logic [2:0]      adj_due_out
);
    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    if (MON_CYCLE_CLKS < 2) begin : g_bad_cycle
        $error("MON_CYCLE_CLKS must be at least 2");
    end
    if (READY_CLKS < 1) begin : g_bad_ready
        $error("READY_CLKS must be at least 1");
    end

    localparam int TICK_W = $clog2(MON_CYCLE_CLKS);
    localparam int RDY_W  = $clog2(READY_CLKS + 1);

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    logic [7:0]        cycle_r;
    logic [7:0]        ctrl1_r;
    logic              run_r;
    logic              lock_r;
    logic              ready_r;
    logic              fans_max_r;
    logic              spin_byp_r;
    logic              to_off_r;
    logic              vcc5_r;
    logic [TICK_W-1:0] tick_cnt_r;
    logic [RDY_W-1:0]  rdy_cnt_r;
    logic [7:0]        rdata_nxt;

    // ------------------------------------------------------------
    // Address decode and write qualifiers
    // ------------------------------------------------------------
    wire hit_cycle = reg_addr_in == fmcr_pkg::FAN_START_TEMP_ADJ_CYCLE_OFS;
    wire hit_ctrl1 = reg_addr_in == fmcr_pkg::FAN_START_TEMP_CTRL1_OFS;
    wire hit_cfg   = reg_addr_in == fmcr_pkg::MON_GLOBAL_CFG_OFS;
    // Locked writes are dropped silently, except the fans-max bit, as the host gets no error path
    wire wr_cycle  = reg_wr_in && hit_cycle && !lock_r;
    wire wr_ctrl1  = reg_wr_in && hit_ctrl1 && !lock_r;
    wire wr_cfg    = reg_wr_in && hit_cfg;
    wire wr_cfg_lk = wr_cfg && !lock_r;

    // Assembled configuration readback, reserved bit fixed
    wire [7:0] cfg_view = {vcc5_r, to_off_r, spin_byp_r,
                           fmcr_pkg::RSVD_READ_VAL[0],
                           fans_max_r, ready_r, lock_r, run_r};

    // Read mux, unmapped offsets read as zero
    assign rdata_nxt = hit_cycle ? cycle_r :
                       hit_ctrl1 ? (ctrl1_r & ~fmcr_pkg::CTRL1_RSVD_MASK) :
                       hit_cfg   ? cfg_view : 8'h00;

    // ------------------------------------------------------------
    // Cycle code register and control register 1
    // ------------------------------------------------------------
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            cycle_r <= fmcr_pkg::FAN_START_TEMP_ADJ_CYCLE_RST;
            ctrl1_r <= fmcr_pkg::FAN_START_TEMP_CTRL1_RST;
        end else begin
            if (wr_cycle) cycle_r <= reg_wdata_in;
            if (wr_ctrl1) ctrl1_r <= reg_wdata_in & ~fmcr_pkg::CTRL1_RSVD_MASK;
        end
    end

    // ------------------------------------------------------------
    // Global configuration bits
    // ------------------------------------------------------------
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            run_r      <= fmcr_pkg::MON_GLOBAL_CFG_RST[fmcr_pkg::CFG_RUN];
            lock_r     <= fmcr_pkg::MON_GLOBAL_CFG_RST[fmcr_pkg::CFG_LOCK];
            fans_max_r <= fmcr_pkg::MON_GLOBAL_CFG_RST[fmcr_pkg::CFG_FANS_MAX];
            spin_byp_r <= fmcr_pkg::MON_GLOBAL_CFG_RST[fmcr_pkg::CFG_SPIN_BYP];
            to_off_r   <= fmcr_pkg::MON_GLOBAL_CFG_RST[fmcr_pkg::CFG_TO_OFF];
            vcc5_r     <= fmcr_pkg::MON_GLOBAL_CFG_RST[fmcr_pkg::CFG_VCC_5V];
        end else begin
            if (wr_cfg_lk) begin
                run_r      <= reg_wdata_in[fmcr_pkg::CFG_RUN];
                spin_byp_r <= reg_wdata_in[fmcr_pkg::CFG_SPIN_BYP];
                to_off_r   <= reg_wdata_in[fmcr_pkg::CFG_TO_OFF];
                vcc5_r     <= reg_wdata_in[fmcr_pkg::CFG_VCC_5V];
                // Write-once: only a reset (power cycle) can clear it
                if (reg_wdata_in[fmcr_pkg::CFG_LOCK]) lock_r <= 1'b1;
            end
            if (wr_cfg) fans_max_r <= reg_wdata_in[fmcr_pkg::CFG_FANS_MAX];
        end
    end

    // ------------------------------------------------------------
    // Power-up ready delay
    // ------------------------------------------------------------
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            rdy_cnt_r <= '0;
            ready_r   <= 1'b0;
        end else if (!ready_r) begin
            rdy_cnt_r <= rdy_cnt_r + 1'b1;
            ready_r   <= rdy_cnt_r == RDY_W'(READY_CLKS - 1);
        end
    end

    // ------------------------------------------------------------
    // Monitoring-cycle enable divider
    // ------------------------------------------------------------
    wire tick_wrap = tick_cnt_r == TICK_W'(MON_CYCLE_CLKS - 1);

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            tick_cnt_r       <= '0;
            monitor_tick_out <= 1'b0;
        end else begin
            tick_cnt_r       <= tick_wrap ? '0 : tick_cnt_r + 1'b1;
            // Cycles only count while monitoring runs on programmed limits
            monitor_tick_out <= tick_wrap && ready_r && run_r;
        end
    end

    // ------------------------------------------------------------
    // Channel codes and adjustment timers
    // ------------------------------------------------------------
    wire [2:0] code_a = cycle_r[fmcr_pkg::REMOTE_A_LSB +: 3];
    wire [2:0] code_l = cycle_r[fmcr_pkg::LOCAL_LSB +: 3];
    wire [2:0] code_b = {ctrl1_r[fmcr_pkg::CTRL1_RB_MSB],
                         cycle_r[fmcr_pkg::REMOTE_B_LSB +: 2]};
    wire [8:0] codes  = {code_b, code_l, code_a};

    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_chan
            fmcr_adj_timer #(.CNT_W(CNT_W)) u_timer (
                .mclk_in       (mclk_in),
                .rst_in        (rst_in),
                .cycle_tick_in (monitor_tick_out),
                .code_in       (codes[3*g +: 3]),
                .dir_up_in     (adj_dir_up_in[g]),
                .adjusted_in   (adj_done_in[g]),
                .due_out       (adj_due_out[g])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // Registered outputs
    // ------------------------------------------------------------
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            reg_rdata_out             <= 8'h00;
            remote_a_cycle_code_out   <= 3'h0;
            local_cycle_code_out      <= 3'h0;
            remote_b_cycle_code_out   <= 3'h0;
            use_programmed_limits_out <= 1'b0;
            limits_locked_out         <= 1'b0;
            monitor_ready_out         <= 1'b0;
            fans_max_override_out     <= 1'b0;
            spinup_pulse_bypass_out   <= 1'b0;
            bus_timeout_off_out       <= 1'b0;
            vcc_5v_scale_out          <= 1'b0;
        end else begin
            if (reg_rd_in) reg_rdata_out <= rdata_nxt;
            remote_a_cycle_code_out   <= code_a;
            local_cycle_code_out      <= code_l;
            remote_b_cycle_code_out   <= code_b;
            // Limits stay stored; this only selects which set applies
            use_programmed_limits_out <= run_r;
            limits_locked_out         <= lock_r;
            monitor_ready_out         <= ready_r;
            fans_max_override_out     <= fans_max_r;
            spinup_pulse_bypass_out   <= spin_byp_r;
            bus_timeout_off_out       <= to_off_r;
            vcc_5v_scale_out          <= vcc5_r;
        end
    end
endmodule : fmcr_regs

// ==== verif/fmcr_regs_checker.sv ====
// Assertion checker for the configuration register bank
`timescale 1ns/1ps
module fmcr_regs_checker (
    input wire logic       mclk_in,
    input wire logic       rst_in,
    input wire logic       reg_wr_in,
    input wire logic       reg_rd_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic [2:0] adj_done_in,
    input wire logic [7:0] reg_rdata_out,
    input wire logic [2:0] remote_a_cycle_code_out,
    input wire logic [2:0] local_cycle_code_out,
    input wire logic [2:0] remote_b_cycle_code_out,
    input wire logic       use_programmed_limits_out,
    input wire logic       limits_locked_out,
    input wire logic       monitor_ready_out,
    input wire logic       fans_max_override_out,
    input wire logic       spinup_pulse_bypass_out,
    input wire logic       bus_timeout_off_out,
    input wire logic       vcc_5v_scale_out,
    input wire logic [2:0] adj_due_out
);
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (rst_in);
    // Unlocked cycle write; a lock taken one cycle earlier still lags on the port
    sequence s_cyc_wr;
        reg_wr_in && reg_addr_in == 8'h37 && !limits_locked_out
            && !$past(reg_wr_in && reg_addr_in == 8'h40 && reg_wdata_in[1]);
    endsequence
    a_cyc_write: assert property (s_cyc_wr |-> ##2 {remote_b_cycle_code_out[1:0],
        local_cycle_code_out, remote_a_cycle_code_out} == $past(reg_wdata_in, 2))
        else $error("cycle codes not taken from write");
    a_fans_write: assert property (reg_wr_in && reg_addr_in == 8'h40 |->
        ##2 fans_max_override_out == $past(reg_wdata_in[3], 2))
        else $error("full speed bit not written");
    a_lock_freeze: assert property (limits_locked_out |=> $stable({remote_b_cycle_code_out,
        local_cycle_code_out, remote_a_cycle_code_out, use_programmed_limits_out,
        bus_timeout_off_out, vcc_5v_scale_out})) else $error("locked setting changed");
    a_lock_sticky: assert property (limits_locked_out |=> limits_locked_out)
        else $error("lock released without reset");
    a_cfg_read: assert property (reg_rd_in && reg_addr_in == 8'h40 |=> reg_rdata_out ==
        {vcc_5v_scale_out, bus_timeout_off_out, spinup_pulse_bypass_out, 1'b0,
        fans_max_override_out, monitor_ready_out, limits_locked_out,
        use_programmed_limits_out}) else $error("config readback wrong");
    a_cyc_read: assert property (reg_rd_in && reg_addr_in == 8'h37 |=> reg_rdata_out ==
        {remote_b_cycle_code_out[1:0], local_cycle_code_out, remote_a_cycle_code_out})
        else $error("cycle readback wrong");
    a_unmapped_read: assert property (reg_rd_in && !(reg_addr_in inside {8'h36, 8'h37,
        8'h40}) |=> reg_rdata_out == 8'h00) else $error("unmapped read not zero");
    a_rdata_hold: assert property (!reg_rd_in |=> $stable(reg_rdata_out))
        else $error("read data moved without read");
    a_due_clear: assert property (adj_done_in[0] && adj_due_out[0] |=> !adj_due_out[0])
        else $error("due kept after adjustment");
endmodule : fmcr_regs_checker

bind fmcr_regs fmcr_regs_checker fmcr_regs_checker_inst (.*);

// ==== verif/fmcr_loop_model.sv ====
// Control-loop model that acknowledges adjustment requests on one channel
`timescale 1ns/1ps
module fmcr_loop_model (
    input  wire logic        mclk_in,
    input  wire logic        rst_in,
    input  wire logic        tick_in,
    input  wire logic        due_in,
    output logic             done_out,
    output logic [10:0]      ticks_out,
    output logic [7:0]       hits_out
);
    logic [10:0] cnt_r;
    // One done pulse per request; counts ticks since the last adjustment
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            done_out <= 1'b0;
            cnt_r <= 11'h000;
            ticks_out <= 11'h000;
            hits_out <= 8'h00;
        end else begin
            done_out <= due_in && !done_out;
            if (done_out) begin
                cnt_r <= 11'h000;
            end else if (tick_in) begin
                cnt_r <= cnt_r + 11'h001;
            end
            if (due_in && !done_out) begin
                ticks_out <= cnt_r;
                hits_out <= hits_out + 8'h01;
            end
        end
    end
endmodule : fmcr_loop_model

// ==== verif/fmcr_regs_tb_top.sv ====
// Testbench for the configuration register bank
`timescale 1ns/1ps
module fmcr_regs_tb_top;
    logic        mclk_in = 1'b0;
    logic        rst_in = 1'b1;
    logic        reg_wr_in = 1'b0;
    logic        reg_rd_in = 1'b0;
    logic [7:0]  reg_addr_in = 8'h00;
    logic [7:0]  reg_wdata_in = 8'h00;
    logic [2:0]  adj_dir_up_in = 3'h0;
    logic [1:0]  side_done = 2'b00;
    logic [7:0]  rdata, hits;
    logic [2:0]  ca, cl, cb, due;
    logic        run, lk, rdy, fm, sb, to, v5, tick, done;
    logic [10:0] ticks;
    int          num_errors = 0;
    int          samples_checked = 0;
    always #5 mclk_in = ~mclk_in;
    fmcr_regs #(.MON_CYCLE_CLKS(4), .READY_CLKS(3)) fmcr_regs_inst (.mclk_in(mclk_in),
        .rst_in(rst_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
        .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
        .adj_dir_up_in(adj_dir_up_in), .adj_done_in({side_done, done}), .reg_rdata_out(rdata),
        .remote_a_cycle_code_out(ca), .local_cycle_code_out(cl), .remote_b_cycle_code_out(cb),
        .use_programmed_limits_out(run), .limits_locked_out(lk), .monitor_ready_out(rdy),
        .fans_max_override_out(fm), .spinup_pulse_bypass_out(sb), .bus_timeout_off_out(to),
        .vcc_5v_scale_out(v5), .monitor_tick_out(tick), .adj_due_out(due));
    fmcr_loop_model fmcr_loop_model_inst (.mclk_in(mclk_in), .rst_in(rst_in), .tick_in(tick),
        .due_in(due[0]), .done_out(done), .ticks_out(ticks), .hits_out(hits));
    task automatic chk(input string nm, input logic [10:0] exp, input logic [10:0] got);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk_in);
        reg_wr_in <= 1'b1;
        reg_addr_in <= a;
        reg_wdata_in <= d;
        @(posedge mclk_in);
        reg_wr_in <= 1'b0;
        @(posedge mclk_in);
        #1;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string nm);
        @(posedge mclk_in);
        reg_rd_in <= 1'b1;
        reg_addr_in <= a;
        @(posedge mclk_in);
        reg_rd_in <= 1'b0;
        #1 chk(nm, {3'b000, exp}, {3'b000, rdata});
    endtask : rd
    task automatic close_out();
        $display("checked %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : close_out
    // Hang guard sized well past the longest delay code sweep
    initial begin
        #600us;
        num_errors++;
        close_out();
    end
    // Main sequence
    initial begin
        logic [7:0] h;
        int         wt;
        repeat (2) @(posedge mclk_in);
        rst_in <= 1'b0;
        repeat (8) @(posedge mclk_in);
        rd(8'h40, 8'h04, "cfg reset");
        chk("ready", 11'h001, {10'h000, rdy});
        rd(8'h37, 8'h00, "cyc reset");
        rd(8'h55, 8'h00, "unmapped");
        $display("test reset done");
        wr(8'h37, 8'ha5);
        wr(8'h36, 8'h01);
        chk("codes", 11'h1a5, {2'b00, cb, cl, ca});
        rd(8'h37, 8'ha5, "cyc rb");
        wr(8'h40, 8'hf9);
        chk("cfg outs", 11'h03d, {5'h00, v5, to, sb, fm, lk, run});
        rd(8'h40, 8'hed, "cfg rb");
        wr(8'h40, 8'he8);
        chk("run off", 11'h000, {10'h000, run});
        rd(8'h37, 8'ha5, "kept");
        wr(8'h40, 8'h01);
        $display("test fields done");
        // Sweep every code both ways; the second interval is the clean one
        for (int c = 0; c < 8; c++) begin
            for (int u = 0; u < 2; u++) begin
                wr(8'h37, 8'(c));
                adj_dir_up_in <= 3'(u);
                h = hits;
                wt = 0;
                while (hits != h + 8'h02 && wt < 10000) begin
                    @(posedge mclk_in);
                    wt++;
                end
                chk("interval", 11'(4 << (c + u)), ticks);
                if (wt >= 10000) num_errors++;
            end
        end
        // Unacknowledged channels sit due; one done pulse restarts both
        chk("side due", 11'h003, {9'h000, due[2:1]});
        @(posedge mclk_in);
        side_done <= 2'b11;
        @(posedge mclk_in);
        side_done <= 2'b00;
        @(posedge mclk_in);
        #1 chk("side clear", 11'h000, {9'h000, due[2:1]});
        $display("test timer done");
        wr(8'h40, 8'h4b);
        wr(8'h37, 8'h00);
        wr(8'h36, 8'h00);
        wr(8'h40, 8'h00);
        rd(8'h37, 8'h07, "cyc locked");
        rd(8'h36, 8'h01, "ctl locked");
        rd(8'h40, 8'h47, "cfg locked");
        wr(8'h40, 8'h08);
        rd(8'h40, 8'h4f, "fans locked");
        @(posedge mclk_in);
        rst_in <= 1'b1;
        repeat (2) @(posedge mclk_in);
        rst_in <= 1'b0;
        repeat (8) @(posedge mclk_in);
        rd(8'h40, 8'h04, "cfg power");
        $display("test lock done");
        close_out();
    end
endmodule : fmcr_regs_tb_top
